//--- rtl/tmr8_regs.vh
// tmr8_regs.vh: register offsets, field positions, reset values and encodings of the timer
// assumes: included by the timer design files, word addressed Avalon-MM slave
`ifndef TMR8_REGS_VH
`define TMR8_REGS_VH
// word offsets (byte address = 4 * offset)
`define TMR8_OFS_CTRL 3'h0
`define TMR8_OFS_CLKSEL 3'h1
`define TMR8_OFS_COUNT 3'h2
`define TMR8_OFS_COMPARE 3'h3
`define TMR8_OFS_FLAGS 3'h4
`define TMR8_OFS_IRQEN 3'h5
`define TMR8_OFS_PIN 3'h6
`define TMR8_OFS_PRESC 3'h7
// control fields
`define TMR8_CTRL_WGM_LSB 0
`define TMR8_CTRL_WGM_MSB 1
`define TMR8_CTRL_COM_LSB 4
`define TMR8_CTRL_COM_MSB 5
`define TMR8_CTRL_FORCE_BIT 7
// flag and enable bits
`define TMR8_FLAG_OVF_BIT 0
`define TMR8_FLAG_MATCH_BIT 1
// pin register bits
`define TMR8_PIN_DIR_BIT 0
`define TMR8_PIN_ASYNC_BIT 1
// waveform modes
`define TMR8_WGM_NORMAL 2'h0
`define TMR8_WGM_PCPWM 2'h1
`define TMR8_WGM_CTC 2'h2
`define TMR8_WGM_FAST 2'h3
// output actions
`define TMR8_COM_NONE 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3
// counter extremes
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
// reset values
`define TMR8_RST_CTRL 8'h00
`define TMR8_RST_COUNT 8'h00
`define TMR8_RST_COMPARE 8'h00
`define TMR8_RST_CLKSEL 3'h0
`define TMR8_RST_PRESC 10'h000
`endif

//--- rtl/tmr8_tick_gen.v
// tmr8_tick_gen.v: turns the clock source select field into a one-cycle tick
// assumes: one clock domain; the async source arrives as a synchronous level strobe
`timescale 1ns/10ps
`include "tmr8_regs.vh"
module tmr8_tick_gen (
  input wire ref_clk, // system clock
  input wire reset_n, // synchronous reset, active low
  input wire [2:0] clock_source_sel, // 0 stops, 1 direct, 2..7 divided
  input wire use_async, // take ticks from osc_tick instead of the divider
  input wire osc_tick, // one-cycle strobe standing for an oscillator edge
  output wire timer_tick // one-cycle count enable
);

reg [9:0] presc_ff;
reg [9:0] nxt_presc;
reg tap;

always @* begin
  nxt_presc = presc_ff + 10'h001;
  if (clock_source_sel == 3'h0) begin
    nxt_presc = `TMR8_RST_PRESC;
  end
end

always @(posedge ref_clk) begin
  if (!reset_n) begin
    presc_ff <= `TMR8_RST_PRESC;
  end else begin
    presc_ff <= nxt_presc;
  end
end

// divide ratios 8,32,64,128,256,1024 on terminal counts
always @* begin
  case (clock_source_sel)
    3'h1: tap = 1'b1;
    3'h2: tap = (presc_ff[2:0] == 3'h7);
    3'h3: tap = (presc_ff[4:0] == 5'h1f);
    3'h4: tap = (presc_ff[5:0] == 6'h3f);
    3'h5: tap = (presc_ff[6:0] == 7'h7f);
    3'h6: tap = (presc_ff[7:0] == 8'hff);
    3'h7: tap = (presc_ff == 10'h3ff);
    default: tap = 1'b0;
  endcase
end

// async source bypasses the divider but still stops on select zero
assign timer_tick = use_async ? (osc_tick && (clock_source_sel != 3'h0)) : tap;

endmodule // tmr8_tick_gen

//--- rtl/tmr8_wave.v
// tmr8_wave.v: 8-bit timer/counter with one compare channel, four waveform modes
// assumes: Avalon-MM master with waitrequest, word addressing, 32-bit data, one clock
//
// Overview of operation
// - normal mode counts up, wraps 0xff to 0
// - normal overflow flag set as count hits zero
// - clear-on-match clears counter at compare value
// - compare unbuffered; low write runs to wrap
// - clear-on-match toggle action inverts output per match
// - clear-on-match overflow flag on max-to-zero unless compare is max
// - fast pwm counts to max, then zero
// - fast pwm action two clears match, sets bottom
// - fast pwm overflow flag at max
// - fast pwm extremes give spike or constant
// - fast pwm toggle action, buffered compare
// - phase pwm counts up to max, then down
// - phase pwm action two clears up, sets down
// - phase pwm overflow flag at bottom
// - phase pwm extremes hold output low/high
// - phase pwm bottom transition for missed match
// - mode field sets count, action sets output
// - output reaches pin only when direction out
// - counter advances on prescaled tick or oscillator
// - pwm compare writes buffered, others direct
// - match flag set one tick after equality
// - source zero stops; count write has priority
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/10ps
`include "tmr8_regs.vh"
module tmr8_wave (
  input wire ref_clk, // 200 MHz system clock
  input wire reset_n, // synchronous reset, active low
  input wire [2:0] avs_address, // word address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte lanes, lane 0 carries all fields
  output wire [31:0] avs_readdata, // registered read data
  output wire avs_waitrequest, // stall until access is taken
  input wire osc_tick, // oscillator edge strobe for async operation
  input wire irq_ack_ovf, // acknowledge of overflow request, one cycle
  input wire irq_ack_match, // acknowledge of match request, one cycle
  output wire irq_ovf, // overflow request, level
  output wire irq_match, // match request, level
  output wire wave_out, // compare output pin value
  output wire wave_out_oe_n // pin driven when low
);

////////////////////////////////////////////////////////////////////////////////////////////////
reg [7:0] ctrl_ff;
reg [2:0] clksel_ff;
reg [7:0] count_value_ff;
reg [7:0] compare_value_ff;
reg [7:0] compare_buf_ff;
reg count_down_ff;
reg overflow_flag_ff;
reg match_flag_ff;
reg [1:0] irqen_ff;
reg [1:0] pin_ff;
reg wave_ff;
reg block_ff;
reg ack_ff;
reg [31:0] rdata_ff;
reg [7:0] nxt_count;
reg nxt_down;
reg nxt_wave;
reg [7:0] nxt_compare;
reg nxt_ovf;
reg nxt_match;
reg [31:0] nxt_rdata;
wire [1:0] waveform_mode_sel;
wire [1:0] output_action_sel;
wire timer_tick;
wire lane0;
wire wr_ctrl;
wire wr_count;
wire wr_compare;
wire wr_flags;
wire force_cmp;
wire is_pwm;
wire equal;
wire cmp_hit;
wire at_top;
wire at_bottom;

// pulse: true when the named offset is being written with lane 0 enabled
function wr_hit;
  input [2:0] ofs;
  begin
    wr_hit = avs_write && ack_ff && lane0 && (avs_address == ofs);
  end
endfunction

assign waveform_mode_sel = ctrl_ff[`TMR8_CTRL_WGM_MSB:`TMR8_CTRL_WGM_LSB];
assign output_action_sel = ctrl_ff[`TMR8_CTRL_COM_MSB:`TMR8_CTRL_COM_LSB];
assign lane0 = avs_byteenable[0];
assign wr_ctrl = wr_hit(`TMR8_OFS_CTRL);
assign wr_count = wr_hit(`TMR8_OFS_COUNT);
assign wr_compare = wr_hit(`TMR8_OFS_COMPARE);
assign wr_flags = wr_hit(`TMR8_OFS_FLAGS);
assign force_cmp = wr_ctrl && avs_writedata[`TMR8_CTRL_FORCE_BIT] && !is_pwm;
assign is_pwm = waveform_mode_sel[0];
assign equal = (count_value_ff == compare_value_ff);
// a count write masks the match of the following tick
assign cmp_hit = equal && !block_ff;
assign at_top = (count_value_ff == `TMR8_MAX);
assign at_bottom = (count_value_ff == `TMR8_BOTTOM);

////////////////////////////////////////////////////////////////////////////////////////////////
// bus slave: one wait cycle per access, then ack; reads answer from a register
always @(posedge ref_clk) begin
  if (!reset_n) begin
    ack_ff <= 1'b0;
  end else begin
    ack_ff <= (avs_read || avs_write) && !ack_ff;
  end
end

assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;

always @* begin
  nxt_rdata = 32'h0000_0000;
  case (avs_address)
    `TMR8_OFS_CTRL: nxt_rdata[7:0] = ctrl_ff & 8'h7f;
    `TMR8_OFS_CLKSEL: nxt_rdata[2:0] = clksel_ff;
    `TMR8_OFS_COUNT: nxt_rdata[7:0] = count_value_ff;
    `TMR8_OFS_COMPARE: nxt_rdata[7:0] = is_pwm ? compare_buf_ff : compare_value_ff;
    `TMR8_OFS_FLAGS: nxt_rdata[1:0] = {match_flag_ff, overflow_flag_ff};
    `TMR8_OFS_IRQEN: nxt_rdata[1:0] = irqen_ff;
    `TMR8_OFS_PIN: nxt_rdata[1:0] = pin_ff;
    default: nxt_rdata = 32'h0000_0000;
  endcase
end

always @(posedge ref_clk) begin
  if (!reset_n) begin
    rdata_ff <= 32'h0000_0000;
  end else if (avs_read && !ack_ff) begin
    rdata_ff <= nxt_rdata;
  end
end

assign avs_readdata = rdata_ff;

////////////////////////////////////////////////////////////////////////////////////////////////
tmr8_tick_gen u_tick (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .clock_source_sel(clksel_ff),
  .use_async(pin_ff[`TMR8_PIN_ASYNC_BIT]),
  .osc_tick(osc_tick),
  .timer_tick(timer_tick)
);

////////////////////////////////////////////////////////////////////////////////////////////////
// counter sequence, driven by the mode field alone
always @* begin
  nxt_count = count_value_ff;
  nxt_down = count_down_ff;
  if (timer_tick) begin
    case (waveform_mode_sel)
      `TMR8_WGM_NORMAL: begin
        nxt_count = count_value_ff + 8'h01;
        nxt_down = 1'b0;
      end
      `TMR8_WGM_CTC: begin
        nxt_down = 1'b0;
        if (equal) begin
          nxt_count = `TMR8_BOTTOM;
        end else begin
          nxt_count = count_value_ff + 8'h01;
        end
      end
      `TMR8_WGM_FAST: begin
        nxt_down = 1'b0;
        nxt_count = at_top ? `TMR8_BOTTOM : count_value_ff + 8'h01;
      end
      `TMR8_WGM_PCPWM: begin
        // max and bottom each last one tick as direction turns
        if (at_top) begin
          nxt_down = 1'b1;
          nxt_count = count_value_ff - 8'h01;
        end else if (at_bottom) begin
          nxt_down = 1'b0;
          nxt_count = count_value_ff + 8'h01;
        end else if (count_down_ff) begin
          nxt_count = count_value_ff - 8'h01;
        end else begin
          nxt_count = count_value_ff + 8'h01;
        end
      end
      default: nxt_count = count_value_ff;
    endcase
  end
  if (wr_count) begin
    nxt_count = avs_writedata[7:0];
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////
// compare register: buffered in pwm modes, loaded at max (fast) or max turn (phase)
always @* begin
  nxt_compare = compare_value_ff;
  if (!is_pwm) begin
    if (wr_compare) begin
      nxt_compare = avs_writedata[7:0];
    end
  end else if (timer_tick && at_top) begin
    nxt_compare = compare_buf_ff;
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////
// waveform generator; action field steers output only
always @* begin
  nxt_wave = wave_ff;
  if (timer_tick) begin
    case (waveform_mode_sel)
      `TMR8_WGM_NORMAL, `TMR8_WGM_CTC: begin
        if (cmp_hit) begin
          case (output_action_sel)
            `TMR8_COM_TOGGLE: nxt_wave = !wave_ff;
            `TMR8_COM_CLEAR: nxt_wave = 1'b0;
            `TMR8_COM_SET: nxt_wave = 1'b1;
            default: nxt_wave = wave_ff;
          endcase
        end
      end
      `TMR8_WGM_FAST: begin
        // match wins over bottom set, so compare max holds a constant level
        if (cmp_hit) begin
          case (output_action_sel)
            `TMR8_COM_TOGGLE: nxt_wave = !wave_ff;
            `TMR8_COM_CLEAR: nxt_wave = 1'b0;
            `TMR8_COM_SET: nxt_wave = 1'b1;
            default: nxt_wave = wave_ff;
          endcase
        end else if (at_top) begin
          case (output_action_sel)
            `TMR8_COM_CLEAR: nxt_wave = 1'b1;
            `TMR8_COM_SET: nxt_wave = 1'b0;
            default: nxt_wave = wave_ff;
          endcase
        end
      end
      `TMR8_WGM_PCPWM: begin
        if (output_action_sel[1]) begin
          if (cmp_hit && !at_bottom && !(at_top && !count_down_ff)) begin
            // up-slope match clears for action two, down-slope match sets
            nxt_wave = count_down_ff ^ output_action_sel[0];
          end else if (at_top) begin
            // max turn: settle on the down-slope level when compare is max, the up-slope result when below
            if (compare_value_ff == `TMR8_MAX) begin
              nxt_wave = !output_action_sel[0];
            end else if (count_value_ff == compare_value_ff) begin
              nxt_wave = output_action_sel[0];
            end else if (count_value_ff > compare_value_ff) begin
              nxt_wave = output_action_sel[0];
            end
          end else if (at_bottom) begin
            // bottom: level of the up-slope, missed matches repaired here
            if (compare_value_ff == `TMR8_BOTTOM) begin
              nxt_wave = output_action_sel[0];
            end else begin
              nxt_wave = !output_action_sel[0];
            end
          end
        end
      end
      default: nxt_wave = wave_ff;
    endcase
  end
  if (force_cmp) begin
    case (output_action_sel)
      `TMR8_COM_TOGGLE: nxt_wave = !wave_ff;
      `TMR8_COM_CLEAR: nxt_wave = 1'b0;
      `TMR8_COM_SET: nxt_wave = 1'b1;
      default: nxt_wave = wave_ff;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////
// flags: hardware set wins over a same-cycle clear
always @* begin
  nxt_ovf = overflow_flag_ff;
  nxt_match = match_flag_ff;
  if ((wr_flags && avs_writedata[`TMR8_FLAG_OVF_BIT]) || irq_ack_ovf) begin
    nxt_ovf = 1'b0;
  end
  if ((wr_flags && avs_writedata[`TMR8_FLAG_MATCH_BIT]) || irq_ack_match) begin
    nxt_match = 1'b0;
  end
  if (timer_tick) begin
    case (waveform_mode_sel)
      `TMR8_WGM_NORMAL: if (nxt_count == `TMR8_BOTTOM && at_top) nxt_ovf = 1'b1;
      `TMR8_WGM_CTC: if (at_top && !equal) nxt_ovf = 1'b1;
      `TMR8_WGM_FAST: if (nxt_count == `TMR8_MAX) nxt_ovf = 1'b1;
      `TMR8_WGM_PCPWM: if (nxt_count == `TMR8_BOTTOM) nxt_ovf = 1'b1;
      default: nxt_ovf = nxt_ovf;
    endcase
    // flag lands on the tick that leaves the matching count, with the ctc clear
    if (cmp_hit) begin
      nxt_match = 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk) begin
  if (!reset_n) begin
    ctrl_ff <= `TMR8_RST_CTRL;
    clksel_ff <= `TMR8_RST_CLKSEL;
    count_value_ff <= `TMR8_RST_COUNT;
    compare_value_ff <= `TMR8_RST_COMPARE;
    compare_buf_ff <= `TMR8_RST_COMPARE;
    count_down_ff <= 1'b0;
    overflow_flag_ff <= 1'b0;
    match_flag_ff <= 1'b0;
    irqen_ff <= 2'h0;
    pin_ff <= 2'h0;
    wave_ff <= 1'b0;
    block_ff <= 1'b0;
  end else begin
    if (wr_ctrl) begin
      ctrl_ff <= avs_writedata[7:0] & 8'h7f;
    end
    if (wr_hit(`TMR8_OFS_CLKSEL)) begin
      clksel_ff <= avs_writedata[2:0];
    end
    if (wr_hit(`TMR8_OFS_IRQEN)) begin
      irqen_ff <= avs_writedata[1:0];
    end
    if (wr_hit(`TMR8_OFS_PIN)) begin
      pin_ff <= avs_writedata[1:0];
    end
    if (wr_compare) begin
      compare_buf_ff <= avs_writedata[7:0];
    end
    count_value_ff <= nxt_count;
    count_down_ff <= nxt_down;
    compare_value_ff <= nxt_compare;
    wave_ff <= nxt_wave;
    overflow_flag_ff <= nxt_ovf;
    match_flag_ff <= nxt_match;
    // block stays up across the tick after a count write, even when stopped
    if (wr_count) begin
      block_ff <= 1'b1;
    end else if (timer_tick) begin
      block_ff <= 1'b0;
    end
  end
end

assign irq_ovf = overflow_flag_ff && irqen_ff[`TMR8_FLAG_OVF_BIT];
assign irq_match = match_flag_ff && irqen_ff[`TMR8_FLAG_MATCH_BIT];
assign wave_out = wave_ff;
assign wave_out_oe_n = !pin_ff[`TMR8_PIN_DIR_BIT];

endmodule // tmr8_wave

//--- sim/tmr8_wave_checker.sv
// tmr8_wave_checker.sv: port-level assertions for the timer block
// assumes: bound onto tmr8_wave, one clock, synchronous active-low reset
`timescale 1ns/10ps
module tmr8_wave_checker (
  input wire ref_clk, // system clock
  input wire reset_n, // sync reset, active low
  input wire [2:0] avs_address, // word address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte lanes
  input wire [31:0] avs_readdata, // read data
  input wire avs_waitrequest, // stall
  input wire osc_tick, // oscillator strobe
  input wire irq_ack_ovf, // overflow acknowledge
  input wire irq_ack_match, // match acknowledge
  input wire irq_ovf, // overflow request
  input wire irq_match, // match request
  input wire wave_out, // compare output
  input wire wave_out_oe_n // pin driven when low
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire req = avs_read | avs_write;
  wire pin_wr = avs_write & ~avs_waitrequest & (avs_address == 3'h6);
  ////////////////////////////////////////////////////////////////////////////////
  AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest)
    else $error("waitrequest low on first request cycle");
  AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest || !req)
    else $error("waitrequest held past one cycle");
  AST_WAIT_IDLE: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_RDATA_TOP: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("unused read bits not zero");
  AST_OE_CAUSE: assert property ($changed(wave_out_oe_n) |-> $past(pin_wr))
    else $error("pin direction changed without pin write");
  AST_OVF_STICKY: assert property (irq_ovf && !irq_ack_ovf && !avs_write |=> irq_ovf)
    else $error("overflow request dropped by itself");
  AST_MATCH_STICKY: assert property (irq_match && !irq_ack_match && !avs_write |=> irq_match)
    else $error("match request dropped by itself");
  AST_OVF_ACK: assert property (irq_ack_ovf |=> !irq_ovf)
    else $error("overflow request survived acknowledge");
  cover property (avs_write && !avs_waitrequest);
  cover property ($rose(irq_ovf));
  cover property ($fell(wave_out));
endmodule // tmr8_wave_checker

bind tmr8_wave tmr8_wave_checker chk (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .osc_tick, .irq_ack_ovf,
  .irq_ack_match, .irq_ovf, .irq_match, .wave_out, .wave_out_oe_n);

//--- sim/timer8_waveform_modes_bench.sv
// timer8_waveform_modes_bench.sv: self-checking bench for the 8-bit timer block
// assumes: ticks come from osc_tick (async source) so every count step is bench-paced
`timescale 1ns/10ps
module timer8_waveform_modes_bench;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [2:0] avs_address = 3'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hf;
  reg osc_tick = 1'b0;
  reg irq_ack_ovf = 1'b0;
  reg irq_ack_match = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq_ovf, irq_match, wave_out, wave_out_oe_n;
  integer errors = 0;
  integer checks_done = 0;
  integer hi = 0;
  reg [31:0] rd;
  reg lvl;

  tmr8_wave dut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .osc_tick, .irq_ack_ovf, .irq_ack_match,
    .irq_ovf, .irq_match, .wave_out, .wave_out_oe_n);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task cmp(input string what, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // request stands until an edge sees waitrequest low; only the watchdog ends a hang
  task bus(input [2:0] a, input w, input [7:0] d);
    reg done;
    begin
      done = 1'b0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      while (!done) begin
        @(posedge ref_clk);
        done = (avs_waitrequest === 1'b0);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task rdc(input string what, input [2:0] a, input [31:0] exp);
    begin
      bus(a, 1'b0, 8'h00);
      cmp(what, exp, rd);
    end
  endtask

  // n timer steps per call; the output is sampled once per step to count high steps
  task tick(input integer n);
    begin
      repeat (n) begin
        osc_tick <= 1'b1;
        @(posedge ref_clk);
        osc_tick <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        if (wave_out === 1'b1) hi = hi + 1;
        @(posedge ref_clk);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      rdc("ctrl", 3'h0, 32'h0);
      rdc("count", 3'h2, 32'h0);
      rdc("compare", 3'h3, 32'h0);
      rdc("flags", 3'h4, 32'h0);
      cmp("oe_n", 1, wave_out_oe_n);
      bus(3'h6, 1'b1, 8'h03);
      cmp("oe_n", 0, wave_out_oe_n);
      bus(3'h1, 1'b1, 8'h01);
      bus(3'h5, 1'b1, 8'h03);
      $display("test reset done");
    end
  endtask

  task t_normal;
    begin
      bus(3'h3, 1'b1, 8'h80);
      bus(3'h2, 1'b1, 8'hfe);
      tick(1);
      rdc("count", 3'h2, 32'hff);
      tick(1);
      rdc("count", 3'h2, 32'h0);
      rdc("flags", 3'h4, 32'h1);
      cmp("irq_ovf", 1, irq_ovf);
      irq_ack_ovf <= 1'b1;
      @(posedge ref_clk);
      irq_ack_ovf <= 1'b0;
      @(posedge ref_clk);
      @(posedge ref_clk);
      cmp("irq_ovf", 0, irq_ovf);
      bus(3'h1, 1'b1, 8'h00);
      tick(3);
      rdc("count", 3'h2, 32'h0);
      bus(3'h1, 1'b1, 8'h01);
      $display("test normal done");
    end
  endtask

  task t_ctc;
    begin
      bus(3'h0, 1'b1, 8'h12);
      bus(3'h3, 1'b1, 8'h03);
      bus(3'h2, 1'b1, 8'h00);
      bus(3'h4, 1'b1, 8'h03);
      lvl = wave_out;
      tick(4);
      rdc("count", 3'h2, 32'h0);
      cmp("wave", !lvl, wave_out);
      rdc("flags", 3'h4, 32'h2);
      cmp("irq_match", 1, irq_match);
      bus(3'h4, 1'b1, 8'h03);
      cmp("irq_match", 0, irq_match);
      lvl = wave_out;
      bus(3'h0, 1'b1, 8'h92);
      cmp("forced wave", !lvl, wave_out);
      rdc("flags", 3'h4, 32'h0);
      bus(3'h2, 1'b1, 8'hfd);
      bus(3'h3, 1'b1, 8'h02);
      tick(3);
      rdc("count", 3'h2, 32'h0);
      rdc("flags", 3'h4, 32'h1);
      $display("test ctc done");
    end
  endtask

  // two windows settle the buffered compare, the third is measured
  task pwm(input [1:0] m, input [1:0] ac, input [7:0] c, input integer win, input integer exp);
    begin
      bus(3'h0, 1'b1, {2'b00, ac, 2'b00, m});
      bus(3'h3, 1'b1, c);
      tick(2 * win);
      bus(3'h4, 1'b1, 8'h03);
      hi = 0;
      tick(win);
      cmp("high ticks", exp, hi);
      bus(3'h4, 1'b0, 8'h00);
      cmp("ovf flag", 1, rd & 32'h1);
    end
  endtask

  task t_pwm;
    begin
      pwm(2'h3, 2'h2, 8'h40, 512, 130);
      pwm(2'h3, 2'h3, 8'h40, 512, 382);
      pwm(2'h3, 2'h2, 8'h00, 512, 2);
      pwm(2'h3, 2'h2, 8'hff, 512, 0);
      pwm(2'h3, 2'h1, 8'h10, 512, 256);
      pwm(2'h1, 2'h2, 8'h40, 510, 128);
      pwm(2'h1, 2'h3, 8'h40, 510, 382);
      pwm(2'h1, 2'h2, 8'h00, 510, 0);
      pwm(2'h1, 2'h2, 8'hff, 510, 510);
      $display("test pwm done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // about 42k cycles of traffic are expected; over twice that means a hang
  initial begin
    #(5 * 90000);
    errors = errors + 1;
    wrap_up;
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_normal;
    t_ctc;
    t_pwm;
    wrap_up;
  end
endmodule // timer8_waveform_modes_bench
